// *** rtl/striped_disk_array_ctrl.sv ***
// four-way stripe controller between user fifos and four disk host cores
// Contract
// - stripe is one 512-byte sector; channel advances after each sector
// - user data path 128 bits; channel buffers convert to 32 bits
// - accepted command decoded into per-channel values, request issued to cores
// - engine_busy held until every channel reports idle
// - command_code 00 identify, 01 erase, 10 write, 11 read
// - start_sector is a 48-bit sector address
// - total_capacity resets to 0, then four times core 0 capacity
// - error_flag set while error_detail nonzero, cleared only by reset
// - error_detail packs low error byte of core n at byte n
// - rx_fifo_write only while fill count bits 15:6 not all ones
// - tx_fifo_pop only while level bits 15:5 not all zero
// - tx_fifo_empty is ignored
// - write sector needs one sector in user fifo, two free outbound
// - write sector pops user fifo for 32 cycles
// - read sector needs one sector inbound, two free in user fifo
// - read sector writes user fifo for 32 cycles
// - one channel buffer active per sector, switch after it completes
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module striped_disk_array_ctrl
  import sdac_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [7:0]               paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     command_request,
  input  wire logic [1:0]               command_code,
  input  wire logic [LBW-1:0]           start_sector,
  input  wire logic [LBW-1:0]           sector_count,
  output logic                          engine_busy,
  output logic      [LBW-1:0]           total_capacity,
  output logic                          error_flag,
  output logic      [31:0]              error_detail,
  output chan_cmd_t [NCH-1:0]           core_cmd,
  output logic      [NCH-1:0]           core_req,
  input  chan_stat_t [NCH-1:0]          core_stat,
  input  wire logic [LBW-1:0]           core0_capacity,
  input  wire logic [CNT_MSB:0]         tx_fifo_level,
  input  wire logic                     tx_fifo_empty,
  output logic                          tx_fifo_pop,
  input  wire logic [UDW-1:0]           tx_fifo_read_data,
  input  wire logic [CNT_MSB:0]         rx_fifo_fill_count,
  output logic                          rx_fifo_write,
  output logic      [UDW-1:0]           rx_fifo_write_data,
  output logic      [NCH-1:0]           outbound_write,
  output logic      [UDW-1:0]           outbound_write_data,
  input  wire logic [NCH-1:0][CNT_MSB:0] outbound_fill_count,
  output logic      [NCH-1:0]           inbound_read,
  input  wire logic [NCH-1:0][UDW-1:0]  inbound_read_data,
  input  wire logic [NCH-1:0][CNT_MSB:0] inbound_level
);
  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_MOVE, ST_DRAIN, ST_FINISH} state_t;

  state_t         state_r;
  state_t         state_nxt;
  logic [LBW-1:0] remain_r;
  logic [1:0]     chan_r;
  logic           is_read_r;
  logic           ctrl_en_r;
  logic           pop_d1_r;
  logic           rd_d1_r;
  logic           pump_done;

  // tx_fifo_empty deliberately unused; level and outbound room gate popping
  wire accept_w    = (state_r == ST_IDLE) && command_request && ctrl_en_r;
  wire is_data_w   = (command_code == CMD_WRITE) || (command_code == CMD_READ);
  wire [NCH-1:0] core_busy_w;
  wire [31:0]    detail_w;
  wire wr_ready_w  = has_sector(tx_fifo_level) && two_free(outbound_fill_count[chan_r]);
  wire rd_ready_w  = has_sector(inbound_level[chan_r]) && two_free(rx_fifo_fill_count);
  wire go_w        = (state_r == ST_CHECK) && (remain_r != 48'h0) &&
                     (is_read_r ? rd_ready_w : wr_ready_w);
  wire cores_idle_w = (core_req == 4'h0) && (core_busy_w == 4'h0);

  for (genvar c = 0; c < NCH; c++) begin : g_stat
    assign core_busy_w[c]     = core_stat[c].busy;
    assign detail_w[8*c +: 8] = core_stat[c].err;
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:   if (accept_w) state_nxt = is_data_w ? ST_CHECK : ST_FINISH;
      ST_CHECK: begin
        if (remain_r == 48'h0) begin
          state_nxt = ST_FINISH;
        end else if (go_w) begin
          state_nxt = ST_MOVE;
        end
      end
      ST_MOVE:   if (pump_done) state_nxt = ST_DRAIN;
      ST_DRAIN:  state_nxt = ST_CHECK;
      ST_FINISH: if (cores_idle_w) state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ST_IDLE;
      engine_busy <= 1'b0;
      remain_r    <= 48'h0;
      chan_r      <= 2'h0;
      is_read_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      engine_busy <= (state_nxt != ST_IDLE);
      if (accept_w) begin
        remain_r  <= sector_count;
        chan_r    <= start_sector[1:0];
        is_read_r <= (command_code == CMD_READ);
      end else if (state_r == ST_DRAIN) begin
        remain_r <= remain_r - 48'h1;
        chan_r   <= chan_r + 2'h1;
      end
    end
  end

  // per-channel command fan-out; a request stands until that core shows busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_cmd <= '0;
      core_req <= 4'h0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (accept_w) begin
          core_cmd[c].code <= command_code;
          core_cmd[c].addr <= chan_addr(start_sector, 2'(c));
          core_cmd[c].len  <= chan_len(start_sector, sector_count, 2'(c));
          core_req[c]      <= !is_data_w ||
                              (chan_len(start_sector, sector_count, 2'(c)) != 48'h0);
        end else if (core_stat[c].busy) begin
          core_req[c] <= 1'b0;
        end
      end
    end
  end

  sector_pump u_pump (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (go_w),
    .is_read (is_read_r),
    .chan    (chan_r),
    .tx_pop  (tx_fifo_pop),
    .ib_read (inbound_read),
    .done    (pump_done)
  );

  // data lags each pop or read by one cycle, then is registered out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pop_d1_r            <= 1'b0;
      rd_d1_r             <= 1'b0;
      outbound_write      <= 4'h0;
      outbound_write_data <= '0;
      rx_fifo_write       <= 1'b0;
      rx_fifo_write_data  <= '0;
    end else begin
      pop_d1_r       <= tx_fifo_pop;
      rd_d1_r        <= |inbound_read;
      outbound_write <= pop_d1_r ? (4'h1 << chan_r) : 4'h0;
      rx_fifo_write  <= rd_d1_r;
      if (pop_d1_r) outbound_write_data <= tx_fifo_read_data;
      if (rd_d1_r) rx_fifo_write_data <= inbound_read_data[chan_r];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_capacity <= 48'h0;
      error_detail   <= 32'h0;
      error_flag     <= 1'b0;
    end else begin
      total_capacity <= {core0_capacity[LBW-3:0], 2'b00};
      error_detail   <= detail_w;
      error_flag     <= error_flag || (detail_w != 32'h0);
    end
  end

  // register slave: zero wait states, unmapped addresses answer with pslverr
  wire        setup_w   = psel && !penable;
  wire        wr_acc_w  = psel && penable && pready && pwrite;
  wire        hit_ctrl  = (paddr == OFS_CTRL);
  wire        hit_stat  = (paddr == OFS_STAT);
  wire        hit_capl  = (paddr == OFS_CAPL);
  wire        hit_caph  = (paddr == OFS_CAPH);
  wire        hit_err   = (paddr == OFS_ERR);
  wire        mapped_w  = hit_ctrl | hit_stat | hit_capl | hit_caph | hit_err;
  wire        moving_w  = (state_r == ST_MOVE) || (state_r == ST_DRAIN);
  wire [31:0] stat_w    = {27'h0, moving_w, chan_r, error_flag, engine_busy};
  wire [31:0] rd_mux_w  = hit_ctrl ? {31'h0, ctrl_en_r} :
                          hit_stat ? stat_w :
                          hit_capl ? total_capacity[31:0] :
                          hit_caph ? {16'h0, total_capacity[LBW-1:32]} :
                          hit_err  ? error_detail : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      prdata    <= 32'h0;
      pslverr   <= 1'b0;
      ctrl_en_r <= CTRL_RST;
    end else begin
      pready <= setup_w;
      if (setup_w) begin
        prdata  <= pwrite ? 32'h0 : rd_mux_w;
        pslverr <= !mapped_w;
      end
      if (wr_acc_w && hit_ctrl) ctrl_en_r <= pwdata[CTRL_EN];
    end
  end

  a_accept_busy: assert property (@(posedge pclk) disable iff (!presetn)
    accept_w |=> engine_busy && core_req != 4'h0) else $error("accept did not start command");
  a_code_fanout: assert property (@(posedge pclk) disable iff (!presetn)
    accept_w |=> core_cmd[3].code == $past(command_code)) else $error("command code lost");
  a_start_chan: assert property (@(posedge pclk) disable iff (!presetn)
    accept_w |=> chan_r == $past(start_sector[1:0])) else $error("wrong first channel");
  a_busy_release: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(engine_busy) |-> $past(core_busy_w) == 4'h0) else $error("busy dropped early");
  a_cap_four: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 total_capacity == {$past(core0_capacity[LBW-3:0]), 2'b00}) else $error("capacity wrong");
  a_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (error_flag |=> error_flag) and (error_detail != 32'h0 |-> error_flag)) else $error("error flag");
  a_err_map: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 error_detail[15:8] == $past(core_stat[1].err)) else $error("error byte mapping");
  a_pop_level: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(tx_fifo_pop) |-> $past(has_sector(tx_fifo_level))) else $error("pop without sector");
  a_rx_room: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(|inbound_read) |-> $past(two_free(rx_fifo_fill_count))) else $error("no room for read");
  a_write_span: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(tx_fifo_pop) |-> ##2 outbound_write == (4'h1 << $past(chan_r, 2))) else $error("write lane");
  a_rotate: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_DRAIN |=> chan_r == $past(chan_r) + 2'h1) else $error("no rotation");

  c_write_sector: cover property (@(posedge pclk) disable iff (!presetn) $fell(tx_fifo_pop));
  c_read_sector: cover property (@(posedge pclk) disable iff (!presetn) $fell(rx_fifo_write));
  c_cmd_done: cover property (@(posedge pclk) disable iff (!presetn) $fell(engine_busy));
  c_error: cover property (@(posedge pclk) disable iff (!presetn) $rose(error_flag));
endmodule // striped_disk_array_ctrl

// *** rtl/sdac_pkg.sv ***
// constants, types and helpers shared by the striped disk array controller
package sdac_pkg;
  localparam int         NCH       = 4;
  localparam int         LBW       = 48;
  localparam int         UDW       = 128;
  localparam int         CNT_MSB   = 15;
  localparam int         SEC_LSB   = 5;
  localparam int         TWO_LSB   = 6;
  localparam logic [4:0] BEAT_LAST = 5'h1f;
  localparam logic [1:0] CMD_IDENT = 2'h0;
  localparam logic [1:0] CMD_ERASE = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_READ  = 2'h3;
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_CAPL  = 8'h08;
  localparam logic [7:0] OFS_CAPH  = 8'h0c;
  localparam logic [7:0] OFS_ERR   = 8'h10;
  localparam int         CTRL_EN   = 0;
  localparam logic       CTRL_RST  = 1'b1;

  typedef struct packed {
    logic [1:0]     code;
    logic [LBW-1:0] addr;
    logic [LBW-1:0] len;
  } chan_cmd_t;

  typedef struct packed {
    logic       busy;
    logic [7:0] err;
  } chan_stat_t;

  // first sector that channel ch holds for a run starting at start
  function automatic logic [LBW-1:0] chan_addr(input logic [LBW-1:0] start, input logic [1:0] ch);
    return (start >> 2) + ((ch < start[1:0]) ? 48'h1 : 48'h0);
  endfunction

  // sectors of the run that land on channel ch
  function automatic logic [LBW-1:0] chan_len(input logic [LBW-1:0] start, input logic [LBW-1:0] cnt,
                                                input logic [1:0] ch);
    logic [1:0]   d;
    logic [LBW:0] t;
    d = ch - start[1:0];
    t = {1'b0, cnt} - {47'h0, d} + 49'h3;
    return (cnt > {46'h0, d}) ? t[LBW:2] : 48'h0;
  endfunction

  function automatic logic has_sector(input logic [CNT_MSB:0] lvl);
    return |lvl[CNT_MSB:SEC_LSB];
  endfunction

  function automatic logic two_free(input logic [CNT_MSB:0] cnt);
    return ~&cnt[CNT_MSB:TWO_LSB];
  endfunction
endpackage

// *** rtl/sector_pump.sv ***
// one-sector beat sequencer: 32 pops or inbound reads on one channel
`timescale 1ns/100ps
module sector_pump
  import sdac_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           start,
  input  wire logic           is_read,
  input  wire logic [1:0]     chan,
  output logic                tx_pop,
  output logic [NCH-1:0]      ib_read,
  output logic                done
);
  logic [4:0] beat_r;
  logic       run_r;
  wire        last_w = run_r && (beat_r == BEAT_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beat_r  <= 5'h0;
      run_r   <= 1'b0;
      tx_pop  <= 1'b0;
      ib_read <= 4'h0;
      done    <= 1'b0;
    end else begin
      done <= last_w;
      if (start) begin
        run_r   <= 1'b1;
        beat_r  <= 5'h0;
        tx_pop  <= !is_read;
        ib_read <= is_read ? (4'h1 << chan) : 4'h0;
      end else if (last_w) begin
        run_r   <= 1'b0;
        tx_pop  <= 1'b0;
        ib_read <= 4'h0;
      end else if (run_r) begin
        beat_r <= beat_r + 5'h1;
      end
    end
  end

  a_pump_beats: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(run_r) |-> $past(beat_r) == BEAT_LAST) else $error("sector not 32 beats");
  a_pump_read_one: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(ib_read) && !(tx_pop && |ib_read)) else $error("two channels active");
  c_pump_sector: cover property (@(posedge pclk) disable iff (!presetn) done);
endmodule // sector_pump

// *** test/sdac_far_model.sv ***
// far-side model: four host cores, user transmit fifo, inbound channel buffers
`timescale 1ns/100ps
module sdac_far_model
  import sdac_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [NCH-1:0]          core_req,
  input  wire logic [31:0]             err_in,
  output chan_stat_t [NCH-1:0]         core_stat,
  input  wire logic                    tx_fifo_pop,
  output logic      [UDW-1:0]          tx_fifo_read_data,
  input  wire logic [NCH-1:0]          inbound_read,
  output logic      [NCH-1:0][UDW-1:0] inbound_read_data
);
  logic [3:0]  left_r [NCH];
  logic [31:0] tx_seq_r;
  logic [23:0] ib_seq_r;
  // cores differ in speed; idle data lines toggle between the last word and its inverse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) left_r[c] <= 4'h0;
      tx_seq_r <= 32'h0;
      ib_seq_r <= 24'h0;
      tx_fifo_read_data <= '0;
      inbound_read_data <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (left_r[c] != 4'h0) left_r[c] <= left_r[c] - 4'h1;
        else if (core_req[c] && !core_stat[c].busy) left_r[c] <= 4'(3 + 3 * c);
        inbound_read_data[c] <= inbound_read[c] ? {96'h0, 8'(c), ib_seq_r} : ~inbound_read_data[c];
      end
      tx_fifo_read_data <= tx_fifo_pop ? {96'h0, tx_seq_r} : ~tx_fifo_read_data;
      if (tx_fifo_pop) tx_seq_r <= tx_seq_r + 32'h1;
      if (|inbound_read) ib_seq_r <= ib_seq_r + 24'h1;
    end
  end
  always_comb begin
    for (int c = 0; c < NCH; c++) core_stat[c] = '{busy: left_r[c] != 4'h0, err: err_in[8*c +: 8]};
  end
endmodule // sdac_far_model

// *** test/striped_disk_array_ctrl_test.sv ***
// self-checking bench for the striped disk array controller
`timescale 1ns/100ps
`define CHK(w, e, g) begin comparisons++; if ((e) !== (g)) begin n_fail++; $display("Error %s expected %h seen %h", w, e, g); end end
module striped_disk_array_ctrl_test
  import sdac_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, command_request, engine_busy, error_flag;
  logic tx_fifo_empty, tx_fifo_pop, rx_fifo_write, er, busy_d;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, error_detail, err_in, rnd, rd, exp_tx;
  logic [1:0] command_code;
  logic [LBW-1:0] start_sector, sector_count, total_capacity, core0_capacity;
  chan_cmd_t [NCH-1:0] core_cmd;
  chan_stat_t [NCH-1:0] core_stat;
  logic [NCH-1:0] core_req, outbound_write, inbound_read, ob_d, ib_d, cbusy;
  logic [15:0] tx_fifo_level, rx_fifo_fill_count, lvl_d, fill_d;
  logic [UDW-1:0] tx_fifo_read_data, rx_fifo_write_data, outbound_write_data;
  logic [NCH-1:0][15:0] outbound_fill_count, inbound_level;
  logic [NCH-1:0][UDW-1:0] inbound_read_data;
  logic [23:0] exp_rx;
  logic [1:0] ch_q[$];
  int n_fail, comparisons, pop_run, wr_run;
  int cn[4] = '{1, 2, 5, 3};
  assign outbound_fill_count = '0;
  assign inbound_level = {4{16'h0040}};
  assign cbusy = {core_stat[3].busy, core_stat[2].busy, core_stat[1].busy, core_stat[0].busy};

  striped_disk_array_ctrl i_striped_disk_array_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .command_request(command_request), .command_code(command_code), .start_sector(start_sector),
    .sector_count(sector_count), .engine_busy(engine_busy), .total_capacity(total_capacity),
    .error_flag(error_flag), .error_detail(error_detail), .core_cmd(core_cmd), .core_req(core_req),
    .core_stat(core_stat), .core0_capacity(core0_capacity), .tx_fifo_level(tx_fifo_level),
    .tx_fifo_empty(tx_fifo_empty), .tx_fifo_pop(tx_fifo_pop), .tx_fifo_read_data(tx_fifo_read_data),
    .rx_fifo_fill_count(rx_fifo_fill_count), .rx_fifo_write(rx_fifo_write), .rx_fifo_write_data(rx_fifo_write_data),
    .outbound_write(outbound_write), .outbound_write_data(outbound_write_data),
    .outbound_fill_count(outbound_fill_count), .inbound_read(inbound_read), .inbound_read_data(inbound_read_data),
    .inbound_level(inbound_level));
  sdac_far_model i_sdac_far_model (.pclk(pclk), .presetn(presetn), .core_req(core_req), .err_in(err_in),
    .core_stat(core_stat), .tx_fifo_pop(tx_fifo_pop), .tx_fifo_read_data(tx_fifo_read_data),
    .inbound_read(inbound_read), .inbound_read_data(inbound_read_data));

  always #2 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] oh(input logic [3:0] v);
    return v[1] ? 2'h1 : v[2] ? 2'h2 : v[3] ? 2'h3 : 2'h0;
  endfunction

  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [1:0] code, input logic [47:0] st, input int cnt);
    logic [47:0] a;
    int l;
    int n;
    logic [3:0] m;
    ch_q.delete();
    @(posedge pclk);
    command_request <= 1'b1;
    command_code <= code;
    start_sector <= st;
    sector_count <= 48'(cnt);
    @(posedge pclk);
    command_request <= 1'b0;
    #1;
    for (int c = 0; c < NCH; c++) begin
      a = (st >> 2) + ((c < st[1:0]) ? 48'h1 : 48'h0);
      l = 0;
      for (int i = 0; i < cnt; i++) if ((st[1:0] + i) % 4 == c) l++;
      m[c] = (code < 2) || (l != 0);
      `CHK("cmd code", code, core_cmd[c].code)
      `CHK("cmd addr", a, core_cmd[c].addr)
      `CHK("cmd len", 48'(l), core_cmd[c].len)
    end
    `CHK("core req", m, core_req)
    `CHK("busy", 1'b1, engine_busy)
    n = 0;
    while (engine_busy !== 1'b0 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (code >= 2) begin
      `CHK("sectors", cnt, ch_q.size())
      foreach (ch_q[i]) `CHK("channel", 2'(st[1:0] + i), ch_q[i])
    end
  endtask

  // random flow control; levels changed only outside bursts, tx_fifo_empty every cycle
  always @(posedge pclk) begin
    rnd <= lfsr(rnd);
    tx_fifo_empty <= rnd[3];
    if (!tx_fifo_pop) tx_fifo_level <= rnd[0] ? 16'h0020 : 16'h001f;
    if (!(|inbound_read) && !rx_fifo_write) rx_fifo_fill_count <= rnd[1] ? 16'hff80 : 16'hffc0;
  end

  always @(posedge pclk) if (presetn) begin
    if (tx_fifo_pop) begin
      if (pop_run == 0) `CHK("tx level", 1'b1, |lvl_d[15:5])
      pop_run++;
    end else if (pop_run != 0) begin
      `CHK("pop run", 32, pop_run)
      pop_run = 0;
    end
    if (rx_fifo_write) begin
      `CHK("rx data", {96'h0, 6'h0, ch_q[$], exp_rx}, rx_fifo_write_data)
      exp_rx++;
      wr_run++;
    end else if (wr_run != 0) begin
      `CHK("write run", 32, wr_run)
      wr_run = 0;
    end
    if (|outbound_write) begin
      if (ob_d == 4'h0) ch_q.push_back(oh(outbound_write));
      `CHK("one hot", 1, $countones(outbound_write))
      `CHK("out data", {96'h0, exp_tx}, outbound_write_data)
      exp_tx++;
    end
    if (|inbound_read && ib_d == 4'h0) begin
      ch_q.push_back(oh(inbound_read));
      `CHK("rx room", 1'b1, ~&fill_d[15:6])
    end
    if (|cbusy) `CHK("busy held", 1'b1, engine_busy)
    if (busy_d && !engine_busy) `CHK("cores idle", 4'h0, cbusy)
    busy_d = engine_busy;
    lvl_d = tx_fifo_level;
    fill_d = rx_fifo_fill_count;
    ob_d = outbound_write;
    ib_d = inbound_read;
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, command_request, tx_fifo_empty} = '0;
    {paddr, pwdata, command_code, start_sector, sector_count, core0_capacity, err_in} = '0;
    {pop_run, wr_run, exp_tx, exp_rx, busy_d, lvl_d, fill_d, ob_d, ib_d} = '0;
    tx_fifo_level = 16'h0;
    rx_fifo_fill_count = 16'hffc0;
    rnd = 32'h510a;
    repeat (5) @(posedge pclk);
    `CHK("cap reset", 48'h0, total_capacity)
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    `CHK("mapped", 1'b0, er)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 1'b1, er)
    core0_capacity <= {16'h1, rnd};
    apb(1'b0, OFS_CAPL, 32'h0);
    `CHK("capacity", {core0_capacity[45:0], 2'h0}, total_capacity)
    `CHK("cap low", {core0_capacity[29:0], 2'h0}, rd)
    apb(1'b1, OFS_CTRL, 32'h0);
    command_request <= 1'b1;
    repeat (3) @(posedge pclk);
    command_request <= 1'b0;
    #1;
    `CHK("refused", 1'b0, engine_busy)
    apb(1'b1, OFS_CTRL, 32'h1);
    for (int k = 0; k < 4; k++) cmd(2'(k), {18'h0, rnd[29:0]}, cn[k]);
    err_in <= rnd | 32'h1;
    repeat (3) @(posedge pclk);
    `CHK("err detail", err_in, error_detail)
    err_in <= 32'h0;
    repeat (3) @(posedge pclk);
    `CHK("err sticky", 1'b1, error_flag)
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("stat err", 1'b1, rd[1])
    presetn <= 1'b0;
    #1;
    `CHK("err reset", 1'b0, error_flag)
    `CHK("cap reset", 48'h0, total_capacity)
    end_sim;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    end_sim;
  end
endmodule // striped_disk_array_ctrl_test
